// file: inc/boot_sleep_map.vh
`ifndef BOOT_SLEEP_MAP_VH
`define BOOT_SLEEP_MAP_VH

// clock and timing
`define CLK_HZ 25000000
`define BOOT_TIME_US 3000
`define PLL_SETTLE_US 200
`define RESET_MIN_REF_CYCLES 16
`define REF_CLK_HZ 12000000

// boot modes from strap bits {31,30}
`define MODE_PARALLEL 2'b00
`define MODE_FAST_SERIAL 2'b01
`define MODE_SPI_SLAVE 2'b10
`define MODE_STANDALONE 2'b11

// register addresses
`define ADDR_CPU_SPEED 16'hC008
`define ADDR_POWER_CTRL 16'hC00A
`define ADDR_OTG_CTRL 16'hC098
`define ADDR_USB_RST_A 16'hC090
`define ADDR_USB_RST_B 16'hC0B0

// power control fields
`define PWR_SLEEP_BIT 1

// reset vector and boot entry
`define RESET_VECTOR 16'hFF00
`define BOOT_ENTRY 16'hE000

// defaults
`define CPU_SPEED_DEFAULT 4'h0
`define WAKE_EN_DEFAULT 8'h00

// wake source indices
`define WK_USB_RESUME 0
`define WK_OTG_VBUS 1
`define WK_OTG_ID 2
`define WK_PARALLEL 3
`define WK_FAST_SERIAL 4
`define WK_SPI 5
`define WK_IRQ_ONE 6
`define WK_IRQ_ZERO 7
`define WAKE_SOURCES 8

`endif

// file: design/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a bus of pins
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: design/cycle_timer.v
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, done pulses once when the count is one or less
module cycle_timer #(
  parameter WIDTH = 17
) (
  input wire clk,
  input wire sys_rst,
  input wire start,
  input wire [WIDTH-1:0] load_value,
  output reg done,
  output wire busy
);
  reg [WIDTH-1:0] count_reg;
  reg run_reg;

  assign busy = run_reg;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_reg <= {WIDTH{1'b0}};
      run_reg <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count_reg <= load_value;
        run_reg <= 1'b1;
      end
      else if (run_reg)
      begin
        if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end
        else
          count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// file: design/boot_sleep_reset_control.v
// What this block does
// - sample clock strap after reset, need high
// - boot mode from straps at reset release
// - decode straps: parallel, serial, spi, standalone
// - boot runs 3 ms, then straps freed
// - coprocessor: one interface enabled, idle waiting
// - standalone: eeprom outputs, debug uart, role input
// - role input high peripheral, low host
// - other usb ports peripheral, others inputs
// - cpu speed register slows cpu only
// - sleep entered on power control bit 1
// - asleep: gpio kept, memory address low
// - asleep: crystal, pll, booster, transceivers off
// - charge pump off before sleep is left to software; sleep keeps charge_pump_en
// - enabled wake sources end sleep
// - resume execution within 200 us
// - reset defaults, then vector after 200 us
// - usb reset touches only two registers
// - waking host read returns dummy data
`include "boot_sleep_map.vh"
`timescale 1ns/1ps
`default_nettype none
module boot_sleep_reset_control #(
  parameter BOOT_CYCLES = ((`CLK_HZ / 1000) * `BOOT_TIME_US) / 1000,
  parameter SETTLE_CYCLES = ((`CLK_HZ / 1000) * `PLL_SETTLE_US) / 1000,
  parameter RESET_MIN_CYCLES = (`RESET_MIN_REF_CYCLES * `CLK_HZ + `REF_CLK_HZ - 1) / `REF_CLK_HZ,
  parameter TW = 17
) (
  input wire clk,
  input wire sys_rst,
  input wire chip_reset_low_pin,
  input wire clock_source_strap,
  input wire [1:0] boot_strap_pins,
  input wire otg_role_id_input,
  input wire otg_bus_supply,
  input wire usb_resume_signal,
  input wire external_irq_line_zero,
  input wire external_irq_line_one,
  input wire host_read_strobe,
  input wire usb_bus_reset,
  input wire reg_write,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [7:0] wake_enable,
  input wire [15:0] host_read_data,
  output reg [15:0] host_rdata,
  output reg host_rdata_valid,
  output reg [1:0] boot_mode,
  output reg clock_ok,
  output reg boot_busy,
  output reg host_load_allowed,
  output reg parallel_port_en,
  output reg fast_serial_port_en,
  output reg spi_slave_en,
  output reg standalone_mode,
  output reg [1:0] strap_pin_oe,
  output reg debug_uart_en,
  output reg first_otg_usb_port_is_host,
  output reg other_usb_ports_peripheral,
  output reg [3:0] cpu_speed,
  output reg sleep_active,
  output reg mem_addr_force_low,
  output reg crystal_drive_en,
  output reg pll_en,
  output reg booster_en,
  output reg usb_xcvr_en,
  output reg charge_pump_en,
  output reg cpu_run,
  output reg [15:0] cpu_start_addr,
  output reg cpu_start_pulse,
  output reg [15:0] usb_reg_a,
  output reg [15:0] usb_reg_b
);
  localparam ST_RESET = 3'd0;
  localparam ST_SETTLE = 3'd1;
  localparam ST_VECTOR = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_SLEEP = 3'd4;
  localparam ST_WAKE = 3'd5;

  wire [6:0] pins_sync;
  wire rst_pin_low;
  wire strap_s;
  wire [1:0] boot_s;
  wire id_s;
  wire vbus_s;
  wire resume_s;
  wire external_irq_line_zero_s;
  wire external_irq_line_one_s;
  wire [2:0] slow_sync;
  wire hread_s;

  pin_sync #(.WIDTH(7)) u_sync_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({chip_reset_low_pin, clock_source_strap, boot_strap_pins, otg_role_id_input,
      otg_bus_supply, usb_resume_signal}),
    .sync_out(pins_sync)
  );
  pin_sync #(.WIDTH(3)) u_sync_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({external_irq_line_zero, external_irq_line_one, host_read_strobe}),
    .sync_out(slow_sync)
  );

  assign rst_pin_low = ~pins_sync[6];
  assign strap_s = pins_sync[5];
  assign boot_s = pins_sync[4:3];
  assign id_s = pins_sync[2];
  assign vbus_s = pins_sync[1];
  assign resume_s = pins_sync[0];
  assign external_irq_line_zero_s = slow_sync[2];
  assign external_irq_line_one_s = slow_sync[1];
  assign hread_s = slow_sync[0];

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg rst_low_d_reg;
  reg [7:0] low_count_reg;
  reg chip_in_reset_reg;
  reg id_d_reg;
  reg external_irq_line_zero_d_reg;
  reg external_irq_line_one_d_reg;
  reg hread_d_reg;
  reg [7:0] wake_event;

  wire boot_done;
  wire boot_running;
  wire settle_done;
  wire settle_running;
  wire rst_release;
  wire pin_reset_ok;
  wire hread_rise;
  wire wake_hit;
  reg settle_start;

  // reset pin qualified only after min low pulse
  assign pin_reset_ok = low_count_reg >= RESET_MIN_CYCLES[7:0];
  // release counts only after a qualified low pulse
  assign rst_release = rst_low_d_reg & ~rst_pin_low & pin_reset_ok;
  assign hread_rise = hread_s & ~hread_d_reg;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rst_low_d_reg <= 1'b0;
      low_count_reg <= 8'h00;
      chip_in_reset_reg <= 1'b1;
    end
    else
    begin
      rst_low_d_reg <= rst_pin_low;
      if (rst_pin_low)
      begin
        if (low_count_reg != 8'hFF)
          low_count_reg <= low_count_reg + 8'h01;
        if (pin_reset_ok)
          chip_in_reset_reg <= 1'b1;
      end
      else
      begin
        low_count_reg <= 8'h00;
        if (rst_release)
          chip_in_reset_reg <= 1'b0;
      end
    end
  end

  wire chip_rst = sys_rst | (rst_pin_low & pin_reset_ok);

  cycle_timer #(.WIDTH(TW)) u_boot_timer (
    .clk(clk),
    .sys_rst(chip_rst),
    .start(rst_release),
    .load_value(BOOT_CYCLES[TW-1:0]),
    .done(boot_done),
    .busy(boot_running)
  );
  cycle_timer #(.WIDTH(TW)) u_settle_timer (
    .clk(clk),
    .sys_rst(chip_rst),
    .start(settle_start),
    .load_value(SETTLE_CYCLES[TW-1:0]),
    .done(settle_done),
    .busy(settle_running)
  );

  // wake event detection
  always @*
  begin
    wake_event = 8'h00;
    wake_event[`WK_USB_RESUME] = resume_s;
    wake_event[`WK_OTG_VBUS] = vbus_s;
    wake_event[`WK_OTG_ID] = id_s ^ id_d_reg;
    wake_event[`WK_PARALLEL] = hread_rise & (boot_mode == `MODE_PARALLEL);
    wake_event[`WK_FAST_SERIAL] = hread_rise & (boot_mode == `MODE_FAST_SERIAL);
    wake_event[`WK_SPI] = hread_rise & (boot_mode == `MODE_SPI_SLAVE);
    wake_event[`WK_IRQ_ONE] = external_irq_line_one_s ^ external_irq_line_one_d_reg;
    wake_event[`WK_IRQ_ZERO] = external_irq_line_zero_s ^ external_irq_line_zero_d_reg;
  end
  assign wake_hit = |(wake_event & wake_enable);

  wire sleep_req = reg_write & (reg_addr == `ADDR_POWER_CTRL) & reg_wdata[`PWR_SLEEP_BIT];

  always @*
  begin
    state_next = state_reg;
    settle_start = 1'b0;
    case (state_reg)
      ST_RESET:
      begin
        if (rst_release)
        begin
          state_next = ST_SETTLE;
          settle_start = 1'b1;
        end
      end
      ST_SETTLE:
      begin
        if (settle_done)
          state_next = ST_VECTOR;
      end
      ST_VECTOR:
        state_next = ST_RUN;
      ST_RUN:
      begin
        if (sleep_req)
          state_next = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (wake_hit)
        begin
          state_next = ST_WAKE;
          settle_start = 1'b1;
        end
      end
      ST_WAKE:
      begin
        if (settle_done)
          state_next = ST_RUN;
      end
      default:
        state_next = ST_RESET;
    endcase
  end

  always @(posedge clk)
  begin
    if (chip_rst)
    begin
      state_reg <= ST_RESET;
      id_d_reg <= id_s;
      external_irq_line_zero_d_reg <= external_irq_line_zero_s;
      external_irq_line_one_d_reg <= external_irq_line_one_s;
      hread_d_reg <= hread_s;
      boot_mode <= `MODE_PARALLEL;
      clock_ok <= 1'b0;
      boot_busy <= 1'b0;
      host_load_allowed <= 1'b0;
      cpu_speed <= `CPU_SPEED_DEFAULT;
      charge_pump_en <= 1'b0;
      cpu_start_addr <= `RESET_VECTOR;
      cpu_start_pulse <= 1'b0;
      usb_reg_a <= 16'h0000;
      usb_reg_b <= 16'h0000;
      host_rdata <= 16'h0000;
      host_rdata_valid <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      id_d_reg <= id_s;
      external_irq_line_zero_d_reg <= external_irq_line_zero_s;
      external_irq_line_one_d_reg <= external_irq_line_one_s;
      hread_d_reg <= hread_s;
      cpu_start_pulse <= 1'b0;
      host_rdata_valid <= 1'b0;
      if (rst_release)
      begin
        boot_mode <= boot_s;
        clock_ok <= strap_s;
        boot_busy <= 1'b1;
      end
      if (boot_done)
      begin
        boot_busy <= 1'b0;
        host_load_allowed <= 1'b1;
      end
      if (state_reg == ST_VECTOR)
      begin
        cpu_start_addr <= `RESET_VECTOR;
        cpu_start_pulse <= 1'b1;
      end
      else if (cpu_start_pulse)
        cpu_start_addr <= `BOOT_ENTRY;
      if (reg_write & (state_reg == ST_RUN))
      begin
        case (reg_addr)
          `ADDR_CPU_SPEED: cpu_speed <= reg_wdata[3:0];
          `ADDR_OTG_CTRL: charge_pump_en <= reg_wdata[0];
          `ADDR_USB_RST_A: usb_reg_a <= reg_wdata;
          `ADDR_USB_RST_B: usb_reg_b <= reg_wdata;
          default: cpu_speed <= cpu_speed;
        endcase
      end
      if (usb_bus_reset)
      begin
        usb_reg_a <= 16'h0000;
        usb_reg_b <= 16'h0000;
      end
      if (hread_rise)
      begin
        host_rdata_valid <= 1'b1;
        host_rdata <= (state_reg == ST_SLEEP) ? 16'h0000 : host_read_data;
      end
    end
  end

  // pin roles and power gating
  always @*
  begin
    standalone_mode = (boot_mode == `MODE_STANDALONE) & ~boot_busy & ~chip_in_reset_reg;
    parallel_port_en = (boot_mode == `MODE_PARALLEL) & ~chip_in_reset_reg;
    fast_serial_port_en = (boot_mode == `MODE_FAST_SERIAL) & ~chip_in_reset_reg;
    spi_slave_en = (boot_mode == `MODE_SPI_SLAVE) & ~chip_in_reset_reg;
    strap_pin_oe = standalone_mode ? 2'b11 : 2'b00;
    debug_uart_en = standalone_mode;
    first_otg_usb_port_is_host = standalone_mode & ~id_s;
    other_usb_ports_peripheral = standalone_mode;
    sleep_active = (state_reg == ST_SLEEP);
    mem_addr_force_low = sleep_active;
    crystal_drive_en = ~sleep_active;
    pll_en = ~sleep_active;
    booster_en = ~sleep_active;
    usb_xcvr_en = ~sleep_active;
    cpu_run = (state_reg == ST_RUN);
  end
endmodule
`default_nettype wire

// file: verif/boot_sleep_reset_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module boot_sleep_reset_control_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic otg_role_id_input,
  input wire logic reg_write,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [1:0] boot_mode,
  input wire logic standalone_mode,
  input wire logic [1:0] strap_pin_oe,
  input wire logic debug_uart_en,
  input wire logic first_otg_usb_port_is_host,
  input wire logic other_usb_ports_peripheral,
  input wire logic [3:0] cpu_speed,
  input wire logic sleep_active,
  input wire logic mem_addr_force_low,
  input wire logic crystal_drive_en,
  input wire logic pll_en,
  input wire logic booster_en,
  input wire logic usb_xcvr_en,
  input wire logic charge_pump_en,
  input wire logic cpu_run,
  input wire logic [15:0] cpu_start_addr,
  input wire logic cpu_start_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  standalone_pins_a: assert property (standalone_mode && cpu_run
    |-> strap_pin_oe == 2'b11 && debug_uart_en && other_usb_ports_peripheral)
    else $error("standalone pin setup wrong");
  otg_role_a: assert property ((standalone_mode && $stable(otg_role_id_input)) [*4]
    |-> first_otg_usb_port_is_host == !otg_role_id_input)
    else $error("otg port role wrong");
  sleep_entry_a: assert property (cpu_run && reg_write && reg_addr == 16'hc00a && reg_wdata[1]
    |=> sleep_active)
    else $error("sleep request not taken");
  sleep_state_a: assert property (sleep_active |-> mem_addr_force_low
    && !(crystal_drive_en || pll_en || booster_en || usb_xcvr_en || cpu_run))
    else $error("power outputs wrong in sleep");
  cpu_speed_a: assert property (cpu_run && reg_write && reg_addr == 16'hc008
    |=> {12'h000, cpu_speed} == ($past(reg_wdata) & 16'h000f))
    else $error("cpu speed write lost");
  charge_pump_a: assert property (cpu_run && reg_write && reg_addr == 16'hc098
    |=> {15'h0000, charge_pump_en} == ($past(reg_wdata) & 16'h0001))
    else $error("charge pump write lost");
  start_vector_a: assert property (cpu_start_pulse |-> cpu_start_addr == 16'hff00
    ##1 cpu_start_addr == 16'he000 && cpu_run)
    else $error("start vector sequence wrong");
  mode_hold_a: assert property (cpu_run && $past(cpu_run) |-> $stable(boot_mode))
    else $error("boot mode changed while running");
endmodule
bind boot_sleep_reset_control boot_sleep_reset_control_checker chk_u (.*);
`default_nettype wire

// file: verif/host_partner.sv
`timescale 1ns/1ps
`default_nettype none
module host_partner (
  input wire logic clk,
  input wire logic chip_reset_low_pin,
  input wire logic host_load_allowed,
  input wire logic go,
  output logic host_read_strobe,
  output logic [15:0] host_read_data
);
  logic seen_reg = 1'b0;
  logic [2:0] len_reg = 3'h0;
  logic [15:0] noise_reg = 16'h0000;
  // reads held off until boot lets the host in
  always @(posedge clk)
  begin
    seen_reg <= chip_reset_low_pin && (seen_reg || host_load_allowed);
    noise_reg <= noise_reg + 16'h3c5b;
    len_reg <= (go && seen_reg && len_reg == 3'h0) ? 3'h5 : len_reg - {2'b00, len_reg != 3'h0};
  end
  assign host_read_strobe = len_reg != 3'h0;
  assign host_read_data = host_read_strobe ? 16'h5a3c : noise_reg;
endmodule
`default_nettype wire

// file: verif/boot_sleep_reset_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module boot_sleep_reset_control_bench;
  localparam int BC = 50;
  localparam int SC = 20;
  logic clk = 1'b0, sys_rst = 1'b1, chip_reset_low_pin = 1'b1, clock_source_strap = 1'b1;
  logic otg_role_id_input = 1'b1, otg_bus_supply = 1'b0, usb_resume_signal = 1'b0, usb_bus_reset = 1'b0;
  logic external_irq_line_zero = 1'b0, external_irq_line_one = 1'b0, reg_write = 1'b0, go = 1'b0;
  logic [1:0] boot_strap_pins = 2'b00, boot_mode, strap_pin_oe;
  logic [7:0] wake_enable = 8'h00;
  logic [3:0] cpu_speed;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, host_read_data, host_rdata, got;
  logic [15:0] cpu_start_addr, usb_reg_a, usb_reg_b;
  logic host_read_strobe, host_rdata_valid, clock_ok, boot_busy, host_load_allowed, parallel_port_en;
  logic fast_serial_port_en, spi_slave_en, standalone_mode, debug_uart_en, first_otg_usb_port_is_host;
  logic other_usb_ports_peripheral, sleep_active, mem_addr_force_low, crystal_drive_en, pll_en, booster_en;
  logic usb_xcvr_en, charge_pump_en, cpu_run, cpu_start_pulse;
  int fails = 0, cmp_count = 0, n;
  int srcs[5] = '{0, 1, 2, 6, 7};
  always #20 clk = ~clk;
  boot_sleep_reset_control #(.BOOT_CYCLES(BC), .SETTLE_CYCLES(SC)) dut_u (.*);
  host_partner host_u (.clk(clk), .chip_reset_low_pin(chip_reset_low_pin), .host_load_allowed(host_load_allowed),
    .go(go), .host_read_strobe(host_read_strobe), .host_read_data(host_read_data));
  task step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task chkw(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task chkb(input logic s, input logic e);
    chkw({15'h0000, s}, {15'h0000, e});
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_write = 1'b0;
    step(1);
  endtask
  task watch(input int lim, input logic stop);
    n = 0;
    while (n < lim && !(stop && cpu_run === 1'b1))
    begin
      step(1);
      go = 1'b0;
      if (host_rdata_valid === 1'b1) got = host_rdata;
      n++;
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task boot_test(input logic [1:0] m);
    chip_reset_low_pin = 1'b0;
    boot_strap_pins = m;
    step(45);
    chip_reset_low_pin = 1'b1;
    step(8);
    boot_strap_pins = ~m;
    n = 8;
    while (cpu_start_pulse !== 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    chkb(n >= SC && n <= BC + SC + 12, 1'b1);
    chkw(cpu_start_addr, 16'hff00);
    chkb(boot_busy, 1'b1);
    step(1);
    chkw(cpu_start_addr, 16'he000);
    chkb(cpu_run, 1'b1);
    chkw({14'h0000, boot_mode}, {14'h0000, m});
    chkb(clock_ok, 1'b1);
    chkw({12'h000, cpu_speed} | usb_reg_a, 16'h0000);
    n = 0;
    while (boot_busy !== 1'b0 && n < BC + 10)
    begin
      step(1);
      n++;
    end
    chkb(n <= BC && host_load_allowed === 1'b1, 1'b1);
    chkw({12'h000, standalone_mode, spi_slave_en, fast_serial_port_en, parallel_port_en}, 16'h0001 << m);
    $display("boot test done");
  endtask
  task role_test;
    otg_role_id_input = 1'b1;
    step(4);
    chkb(first_otg_usb_port_is_host, 1'b0);
    otg_role_id_input = 1'b0;
    step(4);
    chkb(first_otg_usb_port_is_host, 1'b1);
    chkw({13'h0000, strap_pin_oe, debug_uart_en & other_usb_ports_peripheral}, 16'h0007);
    $display("role test done");
  endtask
  task reg_test;
    wr(16'hc008, 16'h0005);
    wr(16'hc098, 16'h0001);
    wr(16'hc090, 16'h1234);
    wr(16'hc0b0, 16'h5678);
    wr(16'hc0f0, 16'hffff);
    chkw({12'h000, cpu_speed}, 16'h0005);
    chkw(usb_reg_a ^ usb_reg_b, 16'h444c);
    usb_bus_reset = 1'b1;
    step(1);
    usb_bus_reset = 1'b0;
    step(1);
    chkw(usb_reg_a | usb_reg_b, 16'h0000);
    chkw({11'h000, charge_pump_en, cpu_speed}, 16'h0015);
    wr(16'hc090, 16'h00a5);
    chkw(usb_reg_a, 16'h00a5);
    $display("register test done");
  endtask
  task sleep_test(input int k, input logic [7:0] en);
    got = 16'hffff;
    wake_enable = en;
    wr(16'hc098, 16'h0000);
    chkb(charge_pump_en, 1'b0);
    wr(16'hc00a, 16'h0002);
    step(3);
    chkb(sleep_active & mem_addr_force_low, 1'b1);
    chkb(pll_en | crystal_drive_en | booster_en | usb_xcvr_en | cpu_run, 1'b0);
    case (k)
      0: usb_resume_signal = 1'b1;
      1: otg_bus_supply = 1'b1;
      2: otg_role_id_input = ~otg_role_id_input;
      6: external_irq_line_one = ~external_irq_line_one;
      7: external_irq_line_zero = ~external_irq_line_zero;
      default: go = 1'b1;
    endcase
    watch(60, 1'b1);
    usb_resume_signal = 1'b0;
    otg_bus_supply = 1'b0;
    if (en[k]) chkb(n >= SC && n <= SC + 15, 1'b1);
    else chkb(sleep_active, 1'b1);
    if (k >= 3 && k <= 5)
    begin
      chkw(got, 16'h0000);
      go = 1'b1;
      watch(20, 1'b0);
      chkw(got, 16'h5a3c);
    end
    $display("sleep test done");
  endtask
  initial
  begin
    step(3);
    sys_rst = 1'b0;
    boot_test(2'b11);
    role_test;
    for (int m = 0; m < 3; m++)
    begin
      boot_test(m[1:0]);
      if (m == 0) reg_test;
      sleep_test(3 + m, 8'h08 << m);
    end
    foreach (srcs[i]) sleep_test(srcs[i], 8'h01 << srcs[i]);
    sleep_test(7, 8'h7f);
    end_of_test;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
